// ---- core/eeprom_pkg.sv ----
`default_nettype none
package eeprom_pkg;
    localparam logic [3:0] PROG_OFS    = 4'h0;
    localparam logic [3:0] PROT_OFS    = 4'h4;
    localparam logic [3:0] STAT_OFS    = 4'h8;
    localparam logic [3:0] ARRAY_OFS   = 4'hc;
    localparam int         PUMP_BIT    = 0;
    localparam int         LATCH_BIT   = 1;
    localparam int         ERASE_BIT   = 2;
    localparam int         ROW_BIT     = 3;
    localparam int         BYTE_BIT    = 4;
    localparam int         PCLK_BIT    = 5;
    localparam int         OPTP_BIT    = 4;
    localparam logic [7:0] PROG_RST    = 8'h00;
    localparam logic [4:0] PROT_RST    = 5'h1f;
    localparam int         PROT_WIN    = 64;
    localparam int         ADDR_W      = 9;
    localparam logic [8:0] OPT_ADDR    = 9'h1ff;
    localparam int         HOLD_MS     = 10;
    localparam int         CLK_KHZ     = 20000;
    localparam int         HOLD_CYC    = HOLD_MS * CLK_KHZ;
    typedef enum logic [1:0] {
        OP_BULK = 2'h0,
        OP_ROW  = 2'h1,
        OP_BYTE = 2'h3
    } erase_scope_t;
endpackage
`default_nettype wire

// ---- core/eeprom_protect.sv ----
`default_nettype none
module eeprom_protect (
    input  wire logic       sys_clk,
    input  wire logic       rstn,
    input  wire logic       special_mode,
    input  wire logic       wr_en,
    input  wire logic [4:0] wr_data,
    output logic      [4:0] prot_q
);
    logic [6:0] age_q;
    logic       window_open;

    assign window_open = special_mode ||
        (age_q < 7'(eeprom_pkg::PROT_WIN));

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            age_q <= 7'h00;
        end else if (age_q < 7'(eeprom_pkg::PROT_WIN)) begin
            age_q <= age_q + 7'h01;
        end
    end

    // Clearing needs the window; setting back to one never does
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            prot_q <= eeprom_pkg::PROT_RST;
        end else if (wr_en) begin
            prot_q <= window_open ? wr_data : (prot_q | wr_data);
        end
    end

    prot_late_clear_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (!special_mode && age_q >= 7'(eeprom_pkg::PROT_WIN)
         && $past(rstn)) |=> ($past(prot_q) & ~prot_q) == 5'h00)
        else $error("protect bit cleared after window");
endmodule
`default_nettype wire

// ---- core/eeprom_program_erase_control.sv ----
// Implementation choices: the Avalon-MM interface to the registers and the register addresses.
`default_nettype none
module eeprom_program_erase_control (
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    // Avalon-MM slave
    input  wire logic [3:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    // Mode and security
    input  wire logic        special_mode,
    input  wire logic        security_on,
    input  wire logic        expanded_req,
    output logic             expanded_allow,
    // Array side
    input  wire logic [8:0]  array_addr,
    input  wire logic [7:0]  array_wdata,
    input  wire logic        array_we,
    input  wire logic [7:0]  array_rdata_raw,
    output logic      [7:0]  array_rdata,
    output logic             array_rd_valid,
    output logic             hv_on,
    output logic             pump_rc_sel,
    output logic             erase_mode,
    output logic      [1:0]  erase_scope,
    output logic      [8:0]  lat_addr_q,
    output logic      [7:0]  lat_data_q,
    output logic             lat_valid_q,
    output logic             blocked
);
    // ==========================================================
    // Bus slave: one wait cycle on every access
    // ==========================================================
    logic        ack_q;
    logic        req;
    logic        wr_go;
    logic [7:0]  prog_q;
    logic [7:0]  wv;
    logic [4:0]  prot_q;
    logic        prot_wr;
    logic [17:0] hold_q;
    logic        target_prot;

    assign req         = (read || write) && !ack_q;
    assign waitrequest = (read || write) && !ack_q;
    assign wr_go       = write && ack_q;
    assign wv          = writedata[7:0];
    assign prot_wr     = wr_go && address == eeprom_pkg::PROT_OFS;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            readdata <= 32'h0000_0000;
        end else if (req && read) begin
            unique case (address)
                eeprom_pkg::PROG_OFS:  readdata <= {24'h000000, prog_q};
                eeprom_pkg::PROT_OFS:  readdata <= {27'h0000000, prot_q};
                eeprom_pkg::STAT_OFS:  readdata <= {29'h0, lat_valid_q,
                                                    hv_on, |hold_q};
                default:               readdata <= 32'h0000_0000;
            endcase
        end
    end

    // ==========================================================
    // Programming control register
    // ==========================================================
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            prog_q <= eeprom_pkg::PROG_RST;
        end else if (wr_go && address == eeprom_pkg::PROG_OFS) begin
            prog_q <= 8'(wv[5:0]);
            if (wv == 8'h00) begin
                prog_q <= eeprom_pkg::PROG_RST;
            end else if (wv[eeprom_pkg::LATCH_BIT] &&
                         wv[eeprom_pkg::PUMP_BIT] &&
                         !prog_q[eeprom_pkg::LATCH_BIT]) begin
                // Latch and pump together from idle: neither is taken
                prog_q[eeprom_pkg::LATCH_BIT] <= 1'b0;
                prog_q[eeprom_pkg::PUMP_BIT]  <= 1'b0;
            end else if (!wv[eeprom_pkg::LATCH_BIT]) begin
                // Pump needs the latch already set
                prog_q[eeprom_pkg::PUMP_BIT] <= 1'b0;
            end
        end
    end

    assign pump_rc_sel = prog_q[eeprom_pkg::PCLK_BIT];
    assign erase_mode  = prog_q[eeprom_pkg::ERASE_BIT];

    // Scope ignored in program mode; byte overrides row
    always_comb begin
        if (!erase_mode) begin
            erase_scope = eeprom_pkg::OP_BULK;
        end else if (prog_q[eeprom_pkg::BYTE_BIT]) begin
            erase_scope = eeprom_pkg::OP_BYTE;
        end else if (prog_q[eeprom_pkg::ROW_BIT]) begin
            erase_scope = eeprom_pkg::OP_ROW;
        end else begin
            erase_scope = eeprom_pkg::OP_BULK;
        end
    end

    // ==========================================================
    // Block protect
    // ==========================================================
    eeprom_protect u_prot (
        .sys_clk      (sys_clk),
        .rstn         (rstn),
        .special_mode (special_mode),
        .wr_en        (prot_wr),
        .wr_data      (wv[4:0]),
        .prot_q       (prot_q)
    );

    // Quarter of the 512-byte array per protect bit; option cell has its own
    always_comb begin
        if (array_addr == eeprom_pkg::OPT_ADDR) begin
            target_prot = prot_q[eeprom_pkg::OPTP_BIT];
        end else begin
            target_prot = prot_q[array_addr[8:7]];
        end
    end

    // ==========================================================
    // Latch capture and read blocking
    // ==========================================================
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            lat_addr_q  <= 9'h000;
            lat_data_q  <= 8'h00;
            lat_valid_q <= 1'b0;
        end else if (!prog_q[eeprom_pkg::LATCH_BIT]) begin
            lat_valid_q <= 1'b0;
        end else if (array_we && !prog_q[eeprom_pkg::PUMP_BIT] &&
                     !target_prot) begin
            lat_addr_q  <= array_addr;
            lat_data_q  <= array_wdata;
            lat_valid_q <= 1'b1;
        end
    end

    assign array_rd_valid = !prog_q[eeprom_pkg::LATCH_BIT];
    assign array_rdata    = array_rd_valid ? array_rdata_raw : 8'h00;

    // High voltage follows the pump bit, only with a protected-clear latch
    assign hv_on = prog_q[eeprom_pkg::PUMP_BIT] && lat_valid_q;
    assign blocked = prog_q[eeprom_pkg::LATCH_BIT] && array_we && target_prot;

    // Pump-on time counter; the status word shows software only whether it is nonzero
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            hold_q <= 18'h00000;
        end else if (!hv_on) begin
            hold_q <= 18'h00000;
        end else if (hold_q < 18'(eeprom_pkg::HOLD_CYC)) begin
            hold_q <= hold_q + 18'h00001;
        end
    end

    // ==========================================================
    // Security: internal access untouched, expanded modes refused
    // ==========================================================
    assign expanded_allow = expanded_req && !security_on;

    pair_write_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (wr_go && address == eeprom_pkg::PROG_OFS && wv == 8'h03
         && !prog_q[eeprom_pkg::LATCH_BIT]) |=> prog_q[1:0] == 2'b00)
        else $error("latch and pump set in one write");
    zero_clear_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (wr_go && address == eeprom_pkg::PROG_OFS && wv == 8'h00)
        |=> !hv_on && array_rd_valid)
        else $error("zero write left voltage on");
    hv_follow_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        hv_on |-> prog_q[eeprom_pkg::PUMP_BIT])
        else $error("voltage on without pump bit");
    scope_ignore_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        !erase_mode |-> erase_scope == eeprom_pkg::OP_BULK)
        else $error("scope used in program mode");
    byte_wins_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (erase_mode && prog_q[eeprom_pkg::BYTE_BIT])
        |-> erase_scope == eeprom_pkg::OP_BYTE)
        else $error("byte scope lost");
    read_block_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        prog_q[eeprom_pkg::LATCH_BIT] |-> !array_rd_valid)
        else $error("read valid while latched");
    capture_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (prog_q[1:0] == 2'b10 && array_we && !target_prot)
        |=> lat_addr_q == $past(array_addr) && lat_valid_q)
        else $error("array write not captured");
    opt_cell_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (prog_q[1:0] == 2'b10 && array_we && array_addr ==
         eeprom_pkg::OPT_ADDR && !prot_q[eeprom_pkg::OPTP_BIT])
        |=> lat_valid_q)
        else $error("option cell write refused");
    secure_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        security_on |-> !expanded_allow)
        else $error("expanded mode with security");

    // ==========================================================
    // Bus, control, latch, read, scope, voltage and security checks
    // ==========================================================
    sequence ctrl_wr_s;
        wr_go && address == eeprom_pkg::PROG_OFS;
    endsequence

    sequence req_open_s;
        (read || write) && !ack_q;
    endsequence

    sequence latch_wr_s;
        prog_q[eeprom_pkg::LATCH_BIT] && !prog_q[eeprom_pkg::PUMP_BIT]
        && array_we;
    endsequence

    // A stall of one cycle only: masters may rely on the answer coming
    wait_first_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        req_open_s |-> waitrequest)
        else $error("first request cycle not stalled");

    answer_next_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        req_open_s ##1 (read || write) |-> !waitrequest)
        else $error("request stalled twice");

    zero_reset_a: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        (ctrl_wr_s ##0 wv == 8'h00) |=> prog_q == eeprom_pkg::PROG_RST)
        else $error("zero write left control bits");

    pump_drop_a: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        (ctrl_wr_s ##0 !wv[eeprom_pkg::LATCH_BIT])
        |=> !prog_q[eeprom_pkg::PUMP_BIT])
        else $error("pump set without latch");

    rd_mask_a: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        !array_rd_valid |-> array_rdata == 8'h00)
        else $error("array data shown while latched");

    rd_pass_a: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        array_rd_valid |-> array_rdata == array_rdata_raw)
        else $error("array data not passed in read mode");

    row_scope_a: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        (erase_mode && !prog_q[eeprom_pkg::BYTE_BIT]
         && prog_q[eeprom_pkg::ROW_BIT])
        |-> erase_scope == eeprom_pkg::OP_ROW)
        else $error("row scope lost");

    bulk_scope_a: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        (erase_mode && !prog_q[eeprom_pkg::BYTE_BIT]
         && !prog_q[eeprom_pkg::ROW_BIT])
        |-> erase_scope == eeprom_pkg::OP_BULK)
        else $error("bulk scope lost");

    // Voltage with nothing latched would stress the array for no purpose
    hv_latch_a: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        hv_on |-> lat_valid_q)
        else $error("voltage on with empty latch");

    latch_drop_a: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        !prog_q[eeprom_pkg::LATCH_BIT] |=> !lat_valid_q)
        else $error("latch kept after latch bit clear");

    prot_hold_a: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        (latch_wr_s ##0 target_prot)
        |=> $stable(lat_addr_q) && $stable(lat_data_q))
        else $error("protected write latched");

    hold_zero_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        !hv_on |=> hold_q == 18'h00000)
        else $error("pump time kept with voltage off");

    open_mode_a: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        !security_on |-> expanded_allow == expanded_req)
        else $error("expanded request lost without security");

    internal_rd_a: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        (security_on && !prog_q[eeprom_pkg::LATCH_BIT]) |-> array_rd_valid)
        else $error("internal read refused with security");
endmodule
`default_nettype wire

// ---- sim/eeprom_program_erase_control_tb.sv ----
`default_nettype none
module eeprom_program_erase_control_tb;
timeunit 1ns;
timeprecision 1ns;
// ============================================================
// Stimulus and observation
logic        sys_clk = 0, rstn = 0, read = 0, write = 0;
logic        special_mode = 0, security_on = 0, expanded_req = 0;
logic [3:0]  address = 4'h0;
logic [31:0] writedata = 32'h0, readdata, rd;
logic [8:0]  array_addr = 9'h000, lat_addr_q;
logic [7:0]  array_wdata = 8'h00, array_rdata, lat_data_q;
logic [7:0]  array_rdata_raw = 8'h5a;
logic        array_we = 0, waitrequest, expanded_allow, array_rd_valid;
logic        hv_on, pump_rc_sel, erase_mode, lat_valid_q, blocked;
logic [1:0]  erase_scope;
int          fail_count = 0, cmp_count = 0;
logic [7:0]  ev [4] = '{8'h06, 8'h0e, 8'h16, 8'h1e};
logic [1:0]  es [4] = '{2'h0, 2'h1, 2'h3, 2'h3};

eeprom_program_erase_control i_dut (.sys_clk(sys_clk), .rstn(rstn),
    .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .special_mode(special_mode),
    .security_on(security_on), .expanded_req(expanded_req),
    .expanded_allow(expanded_allow), .array_addr(array_addr),
    .array_wdata(array_wdata), .array_we(array_we),
    .array_rdata_raw(array_rdata_raw), .array_rdata(array_rdata),
    .array_rd_valid(array_rd_valid), .hv_on(hv_on),
    .pump_rc_sel(pump_rc_sel), .erase_mode(erase_mode),
    .erase_scope(erase_scope), .lat_addr_q(lat_addr_q),
    .lat_data_q(lat_data_q), .lat_valid_q(lat_valid_q),
    .blocked(blocked));

always #25 sys_clk = ~sys_clk;

// ============================================================
// Shared tasks
task stop_test;
    if (fail_count == 0 && cmp_count > 0)
        $display("bench passed");
    else
        $display("bench failed");
    $finish;
endtask

task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
        fail_count++;
        $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
endtask

// Holds the request until waitrequest is seen low at an edge
task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= !wr;
    n = 0;
    do begin
        @(posedge sys_clk);
        n++;
    end while (waitrequest !== 1'b0 && n < 20);
    if (n >= 20) begin
        fail_count++;
        stop_test();
    end
    rd = readdata;
    write <= 1'b0;
    read <= 1'b0;
endtask

task rchk(input string what, input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(what, rd, exp);
endtask

task awr(input logic [8:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    array_addr <= a;
    array_wdata <= d;
    array_we <= 1'b1;
    @(posedge sys_clk);
    array_we <= 1'b0;
    @(negedge sys_clk);
endtask

// ============================================================
// Scenarios
task t_reset;
    rchk("ctrl", 4'h0, 32'h0);
    rchk("prot", 4'h4, 32'h1f);
    rchk("unmapped", 4'hc, 32'h0);
    bus(1'b1, 4'h4, 32'h0);
    rchk("prot clr", 4'h4, 32'h0);
endtask

task t_program;
    bus(1'b1, 4'h0, 32'h02);
    awr(9'h010, 8'h3c);
    chk("lat valid", lat_valid_q, 1);
    chk("lat addr", lat_addr_q, 9'h010);
    chk("lat data", lat_data_q, 8'h3c);
    chk("rd valid", array_rd_valid, 0);
    bus(1'b1, 4'h0, 32'h03);
    @(negedge sys_clk);
    chk("hv on", hv_on, 1);
    chk("erase mode", erase_mode, 0);
    bus(1'b1, 4'h0, 32'h00);
    @(negedge sys_clk);
    chk("hv off", hv_on, 0);
    chk("rd valid", array_rd_valid, 1);
    chk("rdata", array_rdata, 8'h5a);
    // Latch and pump in one write must both be refused
    bus(1'b1, 4'h0, 32'h03);
    rchk("ctrl both", 4'h0, 32'h0);
    chk("hv both", hv_on, 0);
endtask

task t_erase;
    for (int i = 0; i < 4; i++) begin
        bus(1'b1, 4'h0, {24'h0, ev[i]});
        awr(9'h020, 8'h00);
        bus(1'b1, 4'h0, {24'h0, ev[i] | 8'h01});
        @(negedge sys_clk);
        chk("scope", erase_scope, es[i]);
        chk("hv erase", hv_on, 1);
        bus(1'b1, 4'h0, 32'h0);
    end
endtask

task t_protect;
    repeat (70) @(posedge sys_clk);
    bus(1'b1, 4'h4, 32'h1f);
    bus(1'b1, 4'h4, 32'h00);
    rchk("prot late", 4'h4, 32'h1f);
    bus(1'b1, 4'h0, 32'h02);
    awr(9'h010, 8'h11);
    chk("prot latch", lat_valid_q, 0);
    bus(1'b1, 4'h0, 32'h0);
    special_mode <= 1'b1;
    bus(1'b1, 4'h4, 32'h0f);
    rchk("prot spec", 4'h4, 32'h0f);
    bus(1'b1, 4'h0, 32'h16);
    awr(eeprom_pkg::OPT_ADDR, 8'hff);
    bus(1'b1, 4'h0, 32'h17);
    @(negedge sys_clk);
    chk("opt erase", erase_scope, 2'h3);
    chk("opt erase hv", hv_on, 1);
    bus(1'b1, 4'h0, 32'h0);
    bus(1'b1, 4'h0, 32'h02);
    awr(eeprom_pkg::OPT_ADDR, 8'ha5);
    chk("opt latch", lat_addr_q, eeprom_pkg::OPT_ADDR);
    bus(1'b1, 4'h0, 32'h03);
    @(negedge sys_clk);
    chk("opt hv", hv_on, 1);
    bus(1'b1, 4'h0, 32'h0);
endtask

task t_misc;
    security_on <= 1'b1;
    expanded_req <= 1'b1;
    @(negedge sys_clk);
    chk("exp sec", expanded_allow, 0);
    chk("rd sec", array_rd_valid, 1);
    security_on <= 1'b0;
    @(negedge sys_clk);
    chk("exp open", expanded_allow, 1);
    bus(1'b1, 4'h0, 32'h20);
    @(negedge sys_clk);
    chk("rc clk", pump_rc_sel, 1);
    bus(1'b1, 4'h0, 32'h0);
endtask

initial begin
    repeat (20) @(posedge sys_clk);
    rstn <= 1'b1;
    t_reset();
    t_program();
    t_erase();
    t_protect();
    t_misc();
    stop_test();
end
endmodule
`default_nettype wire
